// *** hdl/charger_status.sv ***
// Charger status lines, battery zones, supply gating and register file.
// Assumes synchronous inputs, one clock, and a classic Wishbone master.
`timescale 1ns/1ns
`default_nettype none
module charger_status
    import charger_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire phase_t phase_i,
    input wire logic signed [7:0] batt_temp_i,
    input wire logic [7:0] die_temp_i,
    input wire logic charge_enable_n_i,
    input wire logic vin_above_2v_i,
    input wire logic vin_headroom_ok_i,
    input wire logic vin_over_ovlo_i,
    input wire logic vin_under_uvlo_i,
    input wire logic status_line_a_i,
    input wire logic status_line_b_i,
    input wire logic status_line_c_i,
    output logic status_line_a_o,
    output logic status_line_b_o,
    output logic status_line_c_o,
    output logic status_line_a_oe_o,
    output logic status_line_b_oe_o,
    output logic status_line_c_oe_o,
    output logic gate_drive_supply_o,
    output logic charger_on_o,
    output logic timer_run_o,
    output logic vbat_reduced_o,
    output logic [6:0] current_target_o,
    output logic irq_o
);

    logic [1:0] ctrl_reg, ctrl_next;
    logic [15:0] therm_reg, therm_next;
    logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [2:0] level_reg, level_next;
    logic gate_reg, gate_next;
    logic on_reg, on_next;
    logic vred_reg, vred_next;
    logic [6:0] target_reg, target_next;
    logic shdn_prev_reg, range_prev_reg, fault_prev_reg;
    logic wr_en, two_line;
    logic signed [7:0] cold_limit;
    logic cold, cool, warm, hot, out_of_range, charging, active;
    logic shutdown, folding;
    logic [6:0] die_target;
    logic [31:0] state_word;
    logic [IRQ_W-1:0] events, w1c;
    cond_t cond;
    logic unused_lines;

    // Line readback is not needed; the host sees the wire directly.
    assign unused_lines = status_line_a_i ^ status_line_b_i ^ status_line_c_i;

    // Battery zones from the thermistor temperature.
    assign two_line = ctrl_reg[CTRL_TWO_LINE_BIT];
    assign cold_limit = ctrl_reg[CTRL_COLD_ZERO_BIT] ?
        COLD_LIMIT_HIGH_C : COLD_LIMIT_LOW_C;
    assign cold = batt_temp_i < cold_limit;
    assign hot = batt_temp_i > HOT_LIMIT_C;
    assign cool = !cold && batt_temp_i < COOL_LIMIT_C;
    assign warm = !hot && batt_temp_i > WARM_LIMIT_C;
    assign out_of_range = cold | hot;
    assign charging = (phase_i == PH_DEAD) || (phase_i == PH_PREQUAL) ||
        (phase_i == PH_FAST) || (phase_i == PH_TOPOFF);

    // Condition bundle for the line encoder.
    always_comb
    begin
        cond.phase = phase_i;
        cond.cold = cold;
        cond.hot = hot;
        cond.ovlo = vin_over_ovlo_i;
        cond.uvlo = vin_under_uvlo_i;
        cond.disabled = charge_enable_n_i;
        cond.no_headroom = !vin_headroom_ok_i;
        cond.shutdown = shutdown;
    end

    status_encoder u_encoder (
        .cond_i(cond),
        .two_line_i(two_line),
        .level_o(level_next)
    );

    die_thermal u_die (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .die_temp_i(die_temp_i),
        .fold_thr_i(therm_reg[THERM_FOLD_LSB +: 8]),
        .shdn_thr_i(therm_reg[THERM_SHDN_LSB +: 8]),
        .target_o(die_target),
        .shutdown_o(shutdown),
        .folding_o(folding)
    );

    // Charger power and current target decisions.
    always_comb
    begin
        gate_next = !charge_enable_n_i && vin_above_2v_i &&
            vin_headroom_ok_i;
        active = gate_next && !shutdown && !vin_under_uvlo_i &&
            !vin_over_ovlo_i && !out_of_range && charging;
        on_next = active;
        vred_next = active && warm;
        if (!active)
            target_next = 7'h00;
        else if (cool)
            target_next = {1'b0, die_target[6:1]};
        else
            target_next = die_target;
    end

    // Readable state word.
    always_comb
    begin
        state_word = 32'h0000_0000;
        state_word[ST_LEVEL_LSB +: 3] = level_reg;
        state_word[ST_COLD_BIT] = cold;
        state_word[ST_COOL_BIT] = cool;
        state_word[ST_WARM_BIT] = warm;
        state_word[ST_HOT_BIT] = hot;
        state_word[ST_SHDN_BIT] = shutdown;
        state_word[ST_FOLD_BIT] = folding;
        state_word[ST_TARGET_LSB +: 7] = target_reg;
        state_word[ST_ON_BIT] = on_reg;
        state_word[ST_GATE_BIT] = gate_reg;
    end

    // Bus slave: ack one cycle after the request, write on the ack edge.
    always_comb
    begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
        rdata_next = rdata_reg;
        ctrl_next = ctrl_reg;
        therm_next = therm_reg;
        irq_mask_next = irq_mask_reg;
        w1c = '0;
        if (ack_next)
        begin
            case (wb_adr_i)
                CTRL_OFS: rdata_next = {30'h0, ctrl_reg};
                STATE_OFS: rdata_next = state_word;
                IRQ_STAT_OFS: rdata_next = {28'h0, irq_stat_reg};
                IRQ_MASK_OFS: rdata_next = {28'h0, irq_mask_reg};
                THERM_OFS: rdata_next = {16'h0, therm_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if (wr_en && wb_sel_i[0])
        begin
            case (wb_adr_i)
                CTRL_OFS: ctrl_next = wb_dat_i[1:0];
                IRQ_STAT_OFS: w1c = wb_dat_i[IRQ_W-1:0];
                IRQ_MASK_OFS: irq_mask_next = wb_dat_i[IRQ_W-1:0];
                THERM_OFS: therm_next[7:0] = wb_dat_i[7:0];
                default: ;
            endcase
        end
        if (wr_en && wb_sel_i[1] && wb_adr_i == THERM_OFS)
            therm_next[15:8] = wb_dat_i[15:8];
    end

    // Sticky events; a new event wins over a clear in the same cycle.
    always_comb
    begin
        events = '0;
        events[IRQ_SHDN_BIT] = shutdown && !shdn_prev_reg;
        events[IRQ_RANGE_BIT] = out_of_range && !range_prev_reg;
        events[IRQ_FAULT_BIT] = (phase_i == PH_TIMER_FAULT) &&
            !fault_prev_reg;
        events[IRQ_CHANGE_BIT] = level_next != level_reg;
        irq_stat_next = (irq_stat_reg & ~w1c) | events;
    end

    // Register everything.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= CTRL_RESET;
            therm_reg <= {SHUTDOWN_RESET, FOLDBACK_RESET};
            irq_stat_reg <= IRQ_RESET;
            irq_mask_reg <= IRQ_RESET;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            level_reg <= L3_RELEASE;
            gate_reg <= 1'b0;
            on_reg <= 1'b0;
            vred_reg <= 1'b0;
            target_reg <= 7'h00;
            shdn_prev_reg <= 1'b0;
            range_prev_reg <= 1'b0;
            fault_prev_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            therm_reg <= therm_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            level_reg <= level_next;
            gate_reg <= gate_next;
            on_reg <= on_next;
            vred_reg <= vred_next;
            target_reg <= target_next;
            shdn_prev_reg <= shutdown;
            range_prev_reg <= out_of_range;
            fault_prev_reg <= (phase_i == PH_TIMER_FAULT);
        end
    end

    // Open-drain pins: data always low, enable pulls for a zero level.
    assign status_line_a_o = 1'b0;
    assign status_line_b_o = 1'b0;
    assign status_line_c_o = 1'b0;
    assign status_line_a_oe_o = ~level_reg[2];
    assign status_line_b_oe_o = ~level_reg[1];
    assign status_line_c_oe_o = ~level_reg[0];
    assign gate_drive_supply_o = gate_reg;
    assign charger_on_o = on_reg;
    assign timer_run_o = on_reg;
    assign vbat_reduced_o = vred_reg;
    assign current_target_o = target_reg;
    assign irq_o = |(irq_stat_reg & irq_mask_reg);
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    property p_cold3;
        @(posedge clk_i) disable iff (rst_i)
        (!two_line && cold && !cond.ovlo && phase_i != PH_TIMER_FAULT &&
            !shutdown && !charge_enable_n_i && !vin_under_uvlo_i &&
            vin_headroom_ok_i) |=> level_reg == L3_COLD;
    endproperty
    a_cold3: assert property (p_cold3)
        else $error("Cold battery did not pull all lines low.");

    property p_fault3;
        @(posedge clk_i) disable iff (rst_i)
        (!two_line && phase_i == PH_TIMER_FAULT && !shutdown &&
            gate_next && !vin_under_uvlo_i) |=> level_reg == L3_FAULT;
    endproperty
    a_fault3: assert property (p_fault3)
        else $error("Timer fault not shown on the three lines.");

    property p_never101;
        @(posedge clk_i) disable iff (rst_i)
        !two_line |=> level_reg != L3_NEVER;
    endproperty
    a_never101: assert property (p_never101)
        else $error("Forbidden three-line code appeared.");

    property p_release3;
        @(posedge clk_i) disable iff (rst_i)
        (!two_line && (shutdown || charge_enable_n_i)) |=>
            level_reg == L3_RELEASE;
    endproperty
    a_release3: assert property (p_release3)
        else $error("Lines not released while disabled.");

    property p_two_never00;
        @(posedge clk_i) disable iff (rst_i)
        two_line |=> !(status_line_a_oe_o && status_line_b_oe_o);
    endproperty
    a_two_never00: assert property (p_two_never00)
        else $error("Both two-line status lines pulled low.");

    property p_two_release;
        @(posedge clk_i) disable iff (rst_i)
        (two_line && phase_i == PH_DONE) |=> level_reg[2:1] == L2_RELEASE;
    endproperty
    a_two_release: assert property (p_two_release)
        else $error("Done state did not release both lines.");

    property p_hot_line_c;
        @(posedge clk_i) disable iff (rst_i)
        two_line |=> status_line_c_oe_o == $past(hot);
    endproperty
    a_hot_line_c: assert property (p_hot_line_c)
        else $error("Line c does not follow the hot battery flag.");

    property p_gate;
        @(posedge clk_i) disable iff (rst_i)
        charge_enable_n_i |=> !gate_drive_supply_o;
    endproperty
    a_gate: assert property (p_gate)
        else $error("Gate supply on while charging is disabled.");

    property p_range_stop;
        @(posedge clk_i) disable iff (rst_i)
        out_of_range |=> !timer_run_o && current_target_o == 7'h00;
    endproperty
    a_range_stop: assert property (p_range_stop)
        else $error("Charging continued outside the battery range.");

    property p_cool_half;
        @(posedge clk_i) disable iff (rst_i)
        (cool && active) |=> current_target_o == $past(die_target) >> 1;
    endproperty
    a_cool_half: assert property (p_cool_half)
        else $error("Cool zone did not halve the current target.");

endmodule
`default_nettype wire

// *** hdl/die_thermal.sv ***
// Die temperature foldback and shutdown with hysteresis.
// Assumes die temperature arrives as unsigned degrees C, clock-synchronous.
`timescale 1ns/1ns
`default_nettype none
module die_thermal
    import charger_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] die_temp_i,
    input wire logic [7:0] fold_thr_i,
    input wire logic [7:0] shdn_thr_i,
    output logic [6:0] target_o,
    output logic shutdown_o,
    output logic folding_o
);

    typedef enum logic [1:0] {TH_NORMAL, TH_FOLD, TH_SHDN} th_state_t;

    th_state_t state_reg, state_next;
    logic [6:0] target_reg, target_next;
    logic [9:0] tick_cnt_reg, tick_cnt_next;
    logic tick;
    logic [7:0] resume_thr;

    // Step divider and the cooled-down resume point.
    assign tick = (tick_cnt_reg == 10'(STEP_CYCLES - 1));
    assign resume_thr = (shdn_thr_i > SHUTDOWN_HYST_C) ?
        shdn_thr_i - SHUTDOWN_HYST_C : 8'h00;

    // Next state: step the target down to the floor, shut down when hot.
    always_comb
    begin
        state_next = state_reg;
        target_next = target_reg;
        tick_cnt_next = tick ? 10'h000 : tick_cnt_reg + 10'h001;
        case (state_reg)
            TH_NORMAL:
            begin
                target_next = TARGET_FULL_PCT;
                if (die_temp_i > fold_thr_i)
                    state_next = TH_FOLD;
            end
            TH_FOLD:
            begin
                if (tick && die_temp_i > fold_thr_i)
                begin
                    if (target_reg >= TARGET_FLOOR_PCT + TARGET_STEP_PCT)
                        target_next = target_reg - TARGET_STEP_PCT;
                    else
                        target_next = TARGET_FLOOR_PCT;
                end
                else if (tick)
                begin
                    if (target_reg + TARGET_STEP_PCT >= TARGET_FULL_PCT)
                        state_next = TH_NORMAL;
                    else
                        target_next = target_reg + TARGET_STEP_PCT;
                end
            end
            TH_SHDN:
            begin
                target_next = TARGET_FLOOR_PCT;
                if (die_temp_i <= resume_thr)
                    state_next = TH_NORMAL;
            end
            default:
                state_next = TH_NORMAL;
        endcase
        if (die_temp_i > shdn_thr_i)
            state_next = TH_SHDN;
    end

    // Register the thermal state.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= TH_NORMAL;
            target_reg <= TARGET_FULL_PCT;
            tick_cnt_reg <= 10'h000;
        end
        else
        begin
            state_reg <= state_next;
            target_reg <= target_next;
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    assign target_o = target_reg;
    assign shutdown_o = (state_reg == TH_SHDN);
    assign folding_o = (state_reg == TH_FOLD);

    property p_fold_floor;
        @(posedge clk_i) disable iff (rst_i)
        target_reg >= TARGET_FLOOR_PCT;
    endproperty
    a_fold_floor: assert property (p_fold_floor)
        else $error("Foldback target fell below the floor.");

    property p_shdn_hold;
        @(posedge clk_i) disable iff (rst_i)
        (state_reg == TH_SHDN && die_temp_i > resume_thr) |=>
            state_reg == TH_SHDN;
    endproperty
    a_shdn_hold: assert property (p_shdn_hold)
        else $error("Shutdown left before the die cooled enough.");

endmodule
`default_nettype wire

// *** hdl/status_encoder.sv ***
// Combinational encoder from charger conditions to status line levels.
// Assumes the caller registers the result before it reaches the pins.
`timescale 1ns/1ns
`default_nettype none
module status_encoder
    import charger_pkg::*;
(
    input wire cond_t cond_i,
    input wire logic two_line_i,
    output logic [2:0] level_o
);

    logic quiet;
    logic charging;

    // Conditions that release every line but the two-line hot line, and the active charge phases.
    assign quiet = cond_i.shutdown | cond_i.disabled | cond_i.uvlo |
        cond_i.no_headroom;
    assign charging = (cond_i.phase == PH_DEAD) ||
        (cond_i.phase == PH_PREQUAL) || (cond_i.phase == PH_FAST) ||
        (cond_i.phase == PH_TOPOFF);

    // Priority encode; release conditions win over any phase.
    always_comb
    begin
        level_o = L3_RELEASE;
        if (!two_line_i)
        begin
            if (quiet)
                level_o = L3_RELEASE;
            else if (cond_i.phase == PH_TIMER_FAULT)
                level_o = L3_FAULT;
            else if (cond_i.ovlo)
                level_o = L3_OVLO;
            else if (cond_i.cold)
                level_o = L3_COLD;
            else if (cond_i.hot)
                level_o = L3_HOT;
            else if (cond_i.phase == PH_DONE)
                level_o = L3_DONE;
            else if (charging)
                level_o = L3_CHARGING;
        end
        else
        begin
            level_o[0] = ~cond_i.hot;
            if (quiet || cond_i.phase == PH_DONE)
                level_o[2:1] = L2_RELEASE;
            else if (cond_i.phase == PH_TIMER_FAULT || cond_i.ovlo ||
                cond_i.cold || cond_i.hot)
                level_o[2:1] = L2_FAULT;
            else if (charging)
                level_o[2:1] = L2_CHARGING;
            else
                level_o[2:1] = L2_RELEASE;
        end
    end

endmodule
`default_nettype wire

// *** shared/charger_pkg.sv ***
// Shared constants and types for the charger status and thermal logic.
// Assumes a single 100 MHz clock and classic Wishbone register access.
package charger_pkg;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATE_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] THERM_OFS = 8'h10;

    // Control register fields and reset value.
    localparam int CTRL_TWO_LINE_BIT = 0;
    localparam int CTRL_COLD_ZERO_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Die thresholds register fields and reset values, in degrees C.
    localparam int THERM_FOLD_LSB = 0;
    localparam int THERM_SHDN_LSB = 8;
    localparam logic [7:0] FOLDBACK_RESET = 8'h73;
    localparam logic [7:0] SHUTDOWN_RESET = 8'h8C;
    localparam logic [7:0] SHUTDOWN_HYST_C = 8'h0F;

    // State register field positions.
    localparam int ST_LEVEL_LSB = 0;
    localparam int ST_COLD_BIT = 3;
    localparam int ST_COOL_BIT = 4;
    localparam int ST_WARM_BIT = 5;
    localparam int ST_HOT_BIT = 6;
    localparam int ST_SHDN_BIT = 7;
    localparam int ST_FOLD_BIT = 8;
    localparam int ST_TARGET_LSB = 9;
    localparam int ST_ON_BIT = 16;
    localparam int ST_GATE_BIT = 17;

    // Interrupt bits.
    localparam int IRQ_W = 4;
    localparam int IRQ_SHDN_BIT = 0;
    localparam int IRQ_RANGE_BIT = 1;
    localparam int IRQ_FAULT_BIT = 2;
    localparam int IRQ_CHANGE_BIT = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    // Battery zone limits in signed degrees C.
    localparam logic signed [7:0] COLD_LIMIT_LOW_C = 8'shF1; // Minus 15 C.
    localparam logic signed [7:0] COLD_LIMIT_HIGH_C = 8'sh00;
    localparam logic signed [7:0] COOL_LIMIT_C = 8'sh0F;
    localparam logic signed [7:0] WARM_LIMIT_C = 8'sh2D;
    localparam logic signed [7:0] HOT_LIMIT_C = 8'sh3C;

    // Charge current targets in percent of the fast-charge setting.
    localparam logic [6:0] TARGET_FULL_PCT = 7'h64;
    localparam logic [6:0] TARGET_FLOOR_PCT = 7'h19;
    localparam logic [6:0] TARGET_STEP_PCT = 7'h05;

    // Foldback step interval.
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_TIME_NS = 10000;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;

    // Status line levels, line a in the top bit.
    localparam logic [2:0] L3_COLD = 3'h0;
    localparam logic [2:0] L3_OVLO = 3'h1;
    localparam logic [2:0] L3_CHARGING = 3'h2;
    localparam logic [2:0] L3_HOT = 3'h3;
    localparam logic [2:0] L3_DONE = 3'h4;
    localparam logic [2:0] L3_NEVER = 3'h5;
    localparam logic [2:0] L3_FAULT = 3'h6;
    localparam logic [2:0] L3_RELEASE = 3'h7;
    localparam logic [1:0] L2_CHARGING = 2'h1;
    localparam logic [1:0] L2_FAULT = 2'h2;
    localparam logic [1:0] L2_RELEASE = 2'h3;

    typedef enum logic [2:0] {
        PH_IDLE, PH_DEAD, PH_PREQUAL, PH_FAST, PH_TOPOFF, PH_DONE,
        PH_TIMER_FAULT
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic cold;
        logic hot;
        logic ovlo;
        logic uvlo;
        logic disabled;
        logic no_headroom;
        logic shutdown;
    } cond_t;

endpackage

// *** tb/status_host.sv ***
// Host side of the open-drain status lines, with one pull-up per line.
// Assumes each enable is high while the block pulls its line.
`timescale 1ns/1ns
`default_nettype none
module status_host
(
    input wire logic [2:0] oe_i,
    input wire logic [2:0] d_i,
    output logic [2:0] wire_o
);
    // A released line floats up to the pull-up level.
    assign wire_o = (oe_i & d_i) | ~oe_i;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Bench for the charger status block: bus, status codes, thermal.
// Assumes status_host models the pull-ups on the status lines.
`timescale 1ns/1ns
`default_nettype none
module tb
    import charger_pkg::*;
;
    logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0, wb_ack_o, irq_o;
    logic [7:0] wb_adr_i = 8'h0, die_temp_i = 8'h19;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    phase_t phase_i = PH_IDLE;
    logic signed [7:0] batt_temp_i = 8'h14;
    logic charge_enable_n_i = 1'h0, vin_above_2v_i = 1'h1;
    logic vin_headroom_ok_i = 1'h1, vin_over_ovlo_i = 1'h0;
    logic vin_under_uvlo_i = 1'h0;
    logic [2:0] oe, d, w;
    logic gate_drive_supply_o, charger_on_o, timer_run_o, vbat_reduced_o;
    logic [6:0] current_target_o;
    int miscompares = 0, samples_checked = 0;

    charger_status u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .phase_i,
        .batt_temp_i, .die_temp_i, .charge_enable_n_i, .vin_above_2v_i,
        .vin_headroom_ok_i, .vin_over_ovlo_i, .vin_under_uvlo_i,
        .status_line_a_i(w[2]), .status_line_b_i(w[1]),
        .status_line_c_i(w[0]), .status_line_a_o(d[2]),
        .status_line_b_o(d[1]), .status_line_c_o(d[0]),
        .status_line_a_oe_o(oe[2]), .status_line_b_oe_o(oe[1]),
        .status_line_c_oe_o(oe[0]), .gate_drive_supply_o, .charger_on_o,
        .timer_run_o, .vbat_reduced_o, .current_target_o, .irq_o);
    status_host u_host (.oe_i(oe), .d_i(d), .wire_o(w));

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    // Prints the verdict and ends the run.
    task automatic results;
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Counts a comparison and reports a mismatch.
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle; read data lands in q.
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= wr;
        wb_adr_i <= a;
        wb_dat_i <= dat;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'h1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (wb_ack_o !== 1'h1)
        begin
            miscompares++;
            results();
        end
        repeat (2) @(posedge clk_i);
    endtask

    // Flags are {disable, overvoltage, undervoltage, headroom, above 2 V}.
    task automatic apply(phase_t p, logic [7:0] t, logic [4:0] f,
        logic [2:0] e);
        phase_i <= p;
        batt_temp_i <= t;
        {charge_enable_n_i, vin_over_ovlo_i, vin_under_uvlo_i,
            vin_headroom_ok_i, vin_above_2v_i} <= f;
        // The host reads the lines only after they have settled.
        repeat (2) @(posedge clk_i);
        chk(w, e);
        chk(gate_drive_supply_o, ~f[4] & f[1] & f[0]);
    endtask

    // Reset, then register reset values and an unmapped read.
    task automatic reset_regs;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk(w, L3_RELEASE);
        bus(1'h0, THERM_OFS, 32'h0);
        chk(q, {16'h0, SHUTDOWN_RESET, FOLDBACK_RESET});
        bus(1'h0, 8'h14, 32'h0);
        chk(q, 32'h0);
    endtask

    // Every three-line code, top-off included, and each release cause but die shutdown.
    task automatic three_line;
        apply(PH_FAST, 8'hEC, 5'h03, L3_COLD);
        apply(PH_FAST, 8'h46, 5'h03, L3_HOT);
        apply(PH_FAST, 8'h14, 5'h0B, L3_OVLO);
        apply(PH_TIMER_FAULT, 8'h14, 5'h03, L3_FAULT);
        apply(PH_DEAD, 8'h14, 5'h03, L3_CHARGING);
        apply(PH_TOPOFF, 8'h14, 5'h03, L3_CHARGING);
        apply(PH_PREQUAL, 8'hF6, 5'h03, L3_CHARGING);
        apply(PH_DONE, 8'h14, 5'h03, L3_DONE);
        apply(PH_FAST, 8'h14, 5'h13, L3_RELEASE);
        apply(PH_FAST, 8'h14, 5'h07, L3_RELEASE);
        apply(PH_FAST, 8'h14, 5'h01, L3_RELEASE);
        apply(PH_IDLE, 8'h14, 5'h02, L3_RELEASE);
    endtask

    // Two-line codes and the hot line, with the 0 C cold limit.
    task automatic two_line;
        bus(1'h1, CTRL_OFS, 32'h3);
        apply(PH_FAST, 8'h14, 5'h03, 3'h3);
        apply(PH_FAST, 8'hFB, 5'h03, 3'h5);
        apply(PH_FAST, 8'h46, 5'h03, 3'h4);
        apply(PH_TIMER_FAULT, 8'h14, 5'h03, 3'h5);
        apply(PH_FAST, 8'h14, 5'h0B, 3'h5);
        apply(PH_DONE, 8'h14, 5'h03, 3'h7);
        apply(PH_FAST, 8'h14, 5'h07, 3'h7);
        bus(1'h1, CTRL_OFS, 32'h0);
    endtask

    // Cool, warm and hot zones, then interrupt status, mask and clear.
    task automatic zones_irq;
        apply(PH_FAST, 8'h0A, 5'h03, L3_CHARGING);
        chk(current_target_o, 7'h32);
        chk(timer_run_o, 1'h1);
        apply(PH_FAST, 8'h32, 5'h03, L3_CHARGING);
        chk(vbat_reduced_o, 1'h1);
        apply(PH_FAST, 8'h46, 5'h03, L3_HOT);
        chk(timer_run_o, 1'h0);
        chk(irq_o, 1'h0);
        bus(1'h0, IRQ_STAT_OFS, 32'h0);
        chk(q, 32'hE);
        bus(1'h1, IRQ_MASK_OFS, 32'h2);
        chk(irq_o, 1'h1);
        bus(1'h1, IRQ_STAT_OFS, 32'h2);
        chk(irq_o, 1'h0);
    endtask

    // Die foldback to the floor, shutdown and resume after cooling.
    task automatic die_heat;
        apply(PH_FAST, 8'h14, 5'h03, L3_CHARGING);
        chk(current_target_o, TARGET_FULL_PCT);
        die_temp_i <= 8'h74;
        repeat (16000) @(posedge clk_i);
        chk(current_target_o, TARGET_FLOOR_PCT);
        die_temp_i <= 8'h8D;
        // Two register stages: the die state, then the line levels.
        repeat (3) @(posedge clk_i);
        chk({w, charger_on_o}, 4'hE);
        die_temp_i <= 8'h7E;
        repeat (50) @(posedge clk_i);
        chk(w, L3_RELEASE);
        die_temp_i <= 8'h7D;
        repeat (3) @(posedge clk_i);
        chk(w, L3_CHARGING);
        bus(1'h0, IRQ_STAT_OFS, 32'h0);
        chk(q[0], 1'h1);
    endtask

    // Runs every scenario in turn, then gives the verdict.
    initial
    begin
        reset_regs();
        three_line();
        two_line();
        zones_irq();
        die_heat();
        results();
    end
endmodule
`default_nettype wire
